// ---- dv/sleep_and_peripheral_clock_gating_tb.sv ----
// Purpose: Self-checking bench of the sleep and clock gating block
// Assumes: AXI4-Lite master tasks, one clock of 125 MHz
// Notes: Port F timer0 is built as absent to see its bit ignored
`timescale 1ns/1ps
`include "spcg_map.vh"

module sleep_and_peripheral_clock_gating_tb;
  reg sys_clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata;
  reg [3:0] wstrb;
  reg awvalid, wvalid, bready, arvalid, rready;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  reg slp, wake, dma_en, adc_sw, adc_done, ac_sw, vref, bod, bod_s, wdt;
  wire [41:0] pclk, blk;
  wire core_en, sleeping, per_en, rtc_en, src_en, buf_off, adc_en, adc_ext;
  wire ac_en, vref_en, bod_en, bod_smp, wdt_run;
  wire [47:0] cnt;
  integer bad_count = 0;
  integer tests_run = 0;
  integer i, k;
  reg lg;
  reg [1:0] rs;
  reg [31:0] d;
  reg [47:0] c;

  always #4 sys_clk_i = ~sys_clk_i;

  spcg_top #(.ADDR_W(8), .IMPL_MASK(42'h3F7FFFFFFFF)) DUT
  (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sleep_instr_i(slp), .wake_i(wake),
    .dma_enabled_i(dma_en), .adc_sw_enable_i(adc_sw),
    .adc_conv_done_i(adc_done), .ac_sw_enable_i(ac_sw),
    .ac_uses_vref_i(vref), .bod_fuse_enable_i(bod),
    .bod_sampled_cfg_i(bod_s), .wdt_enable_i(wdt),
    .peripheral_clock_o(pclk), .periph_access_block_o(blk),
    .core_clk_en_o(core_en), .sleeping_o(sleeping),
    .periph_clk_en_o(per_en), .rtc_clk_en_o(rtc_en),
    .sys_src_en_o(src_en), .input_buffer_off_o(buf_off),
    .adc_enable_o(adc_en), .adc_extended_conv_o(adc_ext),
    .ac_enable_o(ac_en), .vref_enable_o(vref_en), .bod_enable_o(bod_en),
    .bod_sampled_o(bod_smp), .wdt_run_o(wdt_run)
  );

  spcg_periph_model u_periph
  (
    .sys_rst_i(sys_rst_i), .peripheral_clock_i(pclk), .cnt_o(cnt)
  );

  // ********************
  // Shared tasks
  // ********************
  task results;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task chk(input string nm, input [47:0] exp, input [47:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("FAIL %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  // Bounded waits only, so a dead handshake ends the run
  task tmo;
    begin
      bad_count = bad_count + 1;
      $display("FAIL handshake expected answer seen none");
      results;
    end
  endtask

  task wr(input [5:0] idx, input [7:0] v);
    reg done;
    begin
      @(posedge sys_clk_i);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      for (k = 0; k < 40 && !done; k = k + 1)
      begin
        @(posedge sys_clk_i);
        if (awvalid && awready)
          awvalid <= 1'b0;
        if (wvalid && wready)
          wvalid <= 1'b0;
        if (bvalid)
        begin
          rs = bresp;
          bready <= 1'b0;
          done = 1'b1;
        end
      end
      if (!done)
        tmo;
    end
  endtask

  task rd(input [5:0] idx);
    reg done;
    begin
      @(posedge sys_clk_i);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      for (k = 0; k < 40 && !done; k = k + 1)
      begin
        @(posedge sys_clk_i);
        if (arvalid && arready)
          arvalid <= 1'b0;
        if (rvalid)
        begin
          d = rdata;
          rs = rresp;
          rready <= 1'b0;
          done = 1'b1;
        end
      end
      if (!done)
        tmo;
    end
  endtask

  task pulse_slp;
    begin
      @(posedge sys_clk_i);
      slp <= 1'b1;
      @(posedge sys_clk_i);
      slp <= 1'b0;
      repeat (2) @(negedge sys_clk_i);
    end
  endtask

  task pulse_done;
    begin
      @(posedge sys_clk_i);
      adc_done <= 1'b1;
      @(posedge sys_clk_i);
      adc_done <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
    end
  endtask

  function [7:0] msk(input integer idx);
    msk = idx == 0 ? `SPCG_GEN_MASK : idx < 3 ? `SPCG_ANA_MASK :
      idx < 7 ? `SPCG_PORT_MASK : `SPCG_SLEEP_MASK;
  endfunction

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h00000000, 4'hF};
    {slp, wake, dma_en, adc_sw, adc_done, ac_sw} = 6'h00;
    {vref, bod, bod_s, wdt} = 4'hF;
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    // Reset values, then writable bits; peripherals disabled first
    for (i = 0; i < 9; i = i + 1)
    begin
      if (i != 7)
      begin
        rd(i[5:0]);
        chk("reset value", 48'h0, d);
        wr(i[5:0], 8'hFF);
        rd(i[5:0]);
        chk("writable bits", msk(i), d);
      end
    end
    wr(`SPCG_IDX_SLEEP, 8'h00);
    chk("blocked", {28'hFFFFFFF, 6'h3F, 8'h5F} & 42'h3F7FFFFFFFF, blk);
    @(negedge sys_clk_i);
    c = cnt;
    repeat (10) @(negedge sys_clk_i);
    chk("timer frozen", c[15:0], cnt[15:0]);
    chk("events frozen", c[31:16], cnt[31:16]);
    chk("absent kept", c[47:32] + 16'h000A, cnt[47:32]);
    wr(`SPCG_IDX_GEN, 8'h00);
    wr(`SPCG_IDX_PORT_C, 8'h00);
    repeat (3) @(negedge sys_clk_i);
    c = cnt;
    repeat (5) @(negedge sys_clk_i);
    chk("timer resumed", c[15:0] + 16'h0005, cnt[15:0]);
    chk("events resumed", c[31:16] + 16'h0005, cnt[31:16]);
    // DMA gate refuses a one while DMA runs
    dma_en <= 1'b1;
    wr(`SPCG_IDX_GEN, 8'h01);
    rd(`SPCG_IDX_GEN);
    chk("dma refused", 48'h0, d);
    dma_en <= 1'b0;
    wr(`SPCG_IDX_GEN, 8'h01);
    rd(`SPCG_IDX_GEN);
    chk("dma taken", 48'h1, d);
    wr(`SPCG_IDX_GEN, 8'h00);
    wr(6'h07, 8'h01);
    chk("unmapped write", `SPCG_RESP_SLVERR, rs);
    rd(6'h20);
    chk("unmapped read", {`SPCG_RESP_SLVERR, 32'h0}, {rs, d});
    // Converter off then on asks for a long conversion
    adc_sw <= 1'b1;
    pulse_done;
    adc_sw <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    adc_sw <= 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk("extended", 48'h1, adc_ext);
    pulse_done;
    chk("extended done", 48'h0, adc_ext);
    ac_sw <= 1'b1;
    // Every mode code, reserved ones included
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(`SPCG_IDX_SLEEP, {4'h0, i[2:0], 1'b1});
      pulse_slp;
      lg = i != 1 && i != 4 && i != 5;
      chk("sleeping", lg, sleeping);
      if (lg)
      begin
        chk("periph clock", i == 0, per_en);
        chk("rtc clock", i == 0 || i == 3 || i == 7, rtc_en);
        chk("sources", i == 0 || i > 5, src_en);
        chk("buffers off", i != 0, buf_off);
        chk("adc enable", i == 0, adc_en);
        chk("ac enable", i == 0, ac_en);
        chk("reference", 48'h1, vref_en);
        chk("brownout", {i != 0, 1'b1}, {bod_smp, bod_en});
        chk("watchdog", 48'h1, wdt_run);
        c = cnt;
        repeat (4) @(negedge sys_clk_i);
        chk("timer in sleep", c[15:0] + (i == 0 ? 4 : 0), cnt[15:0]);
        @(posedge sys_clk_i);
        wake <= 1'b1;
        @(posedge sys_clk_i);
        wake <= 1'b0;
      end
      for (k = 0; k < 20 && core_en !== 1'b1; k = k + 1)
        @(negedge sys_clk_i);
      if (core_en !== 1'b1)
        tmo;
      wr(`SPCG_IDX_SLEEP, 8'h00);
    end
    wr(`SPCG_IDX_SLEEP, {4'h0, `SPCG_MODE_ALL_OFF, 1'b0});
    pulse_slp;
    chk("unarmed", 48'h0, sleeping);
    results;
  end
endmodule // sleep_and_peripheral_clock_gating_tb

bind spcg_top spcg_top_properties u_props
(
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wake_i(wake_i),
  .adc_conv_done_i(adc_conv_done_i), .ac_sw_enable_i(ac_sw_enable_i),
  .ac_uses_vref_i(ac_uses_vref_i), .bod_fuse_enable_i(bod_fuse_enable_i),
  .wdt_enable_i(wdt_enable_i), .core_clk_en_o(core_clk_en_o),
  .sleeping_o(sleeping_o), .periph_clk_en_o(periph_clk_en_o),
  .input_buffer_off_o(input_buffer_off_o), .adc_enable_o(adc_enable_o),
  .adc_extended_conv_o(adc_extended_conv_o), .ac_enable_o(ac_enable_o),
  .vref_enable_o(vref_enable_o), .bod_enable_o(bod_enable_o),
  .wdt_run_o(wdt_run_o)
);

// ---- dv/spcg_periph_model.sv ----
// Purpose: Gated peripherals seen as free counters on their clocks
// Assumes: Gated clocks run while reset is held
// Notes: Counts port C timer0, event routing and port F timer0
`timescale 1ns/1ps

module spcg_periph_model
(
  input wire sys_rst_i,
  input wire [41:0] peripheral_clock_i,
  output reg [47:0] cnt_o
);
  // Clock bit of each counter, lowest slice first
  localparam [17:0] SEL = {6'h23, 6'h01, 6'h0E};
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_cnt
      // A stopped clock freezes the count; a restart goes on from it
      always @(posedge peripheral_clock_i[SEL[g*6+:6]])
      begin
        if (sys_rst_i)
          cnt_o[g*16+:16] <= 16'h0000;
        else
          cnt_o[g*16+:16] <= cnt_o[g*16+:16] + 16'h0001;
      end
    end
  endgenerate
endmodule // spcg_periph_model

// ---- dv/spcg_top_properties.sv ----
// Purpose: Port-level checks of the sleep and clock gating block
// Assumes: One clock, reset synchronous and active high
// Notes: Bound to spcg_top from the bench top file
`timescale 1ns/1ps

module spcg_top_properties
(
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire wake_i,
  input wire adc_conv_done_i,
  input wire ac_sw_enable_i,
  input wire ac_uses_vref_i,
  input wire bod_fuse_enable_i,
  input wire wdt_enable_i,
  input wire core_clk_en_o,
  input wire sleeping_o,
  input wire periph_clk_en_o,
  input wire input_buffer_off_o,
  input wire adc_enable_o,
  input wire adc_extended_conv_o,
  input wire ac_enable_o,
  input wire vref_enable_o,
  input wire bod_enable_o,
  input wire wdt_run_o
);
  // ********************
  // Assertions, all in the system clock domain
  // ********************
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  core_off_asleep_a: assert property (sleeping_o |-> !core_clk_en_o)
    else $error("core clock runs while asleep");
  wake_exit_a: assert property (sleeping_o && wake_i |=> !sleeping_o)
    else $error("wake request did not end sleep");
  // Halt is four cycles exactly, so a short or long count both fail
  wake_halt_a: assert property ($fell(sleeping_o) |->
    !core_clk_en_o [*4] ##1 core_clk_en_o)
    else $error("core halt after wake is not four cycles");
  buffer_off_a: assert property (sleeping_o && !periph_clk_en_o
    |-> input_buffer_off_o)
    else $error("input buffers on with peripheral clock stopped");
  adc_forced_a: assert property (input_buffer_off_o |-> !adc_enable_o)
    else $error("converter enabled in deep sleep");
  ac_forced_a: assert property (input_buffer_off_o |-> !ac_enable_o)
    else $error("comparator enabled in deep sleep");
  vref_kept_a: assert property (ac_sw_enable_i && ac_uses_vref_i
    |=> vref_enable_o)
    else $error("reference dropped while comparator uses it");
  bod_kept_a: assert property (bod_fuse_enable_i |=> bod_enable_o)
    else $error("brownout detector dropped");
  wdt_kept_a: assert property (wdt_enable_i |=> wdt_run_o)
    else $error("watchdog stopped");
  ext_done_a: assert property (adc_conv_done_i |=> !adc_extended_conv_o)
    else $error("extended flag kept after a conversion");

  cover property ($rose(sleeping_o));
  cover property ($fell(sleeping_o));
  cover property ($fell(adc_extended_conv_o));
endmodule // spcg_top_properties

// ---- rtl/spcg_clock_gate.v ----
// Purpose: Glitch-free clock gate for one peripheral clock.
// Assumes: stop_i comes from logic on clk_i.
// Notes:   Enable is captured on the falling edge, so it only changes
//          while the clock is low and no runt pulse can escape.
`timescale 1ns/1ps

module spcg_clock_gate
(
  input wire clk_i,
  input wire rst_i,
  input wire stop_i,
  output wire clk_o
);

  reg run;

  // Enable taken at the clock-low phase
  always @(negedge clk_i)
  begin
    if (rst_i)
      run <= 1'b1;
    else
      run <= ~stop_i;
  end

  // Frozen peripheral keeps its state and resumes on release
  assign clk_o = clk_i & run;

endmodule // spcg_clock_gate

// ---- rtl/spcg_map.vh ----
// Purpose: Register indices, field positions, reset values and timing
//          counts of the sleep and peripheral clock gating block.
// Assumes: A register index times four gives its AXI4-Lite byte address.
// Notes:   Definitions only.
`ifndef SPCG_MAP_VH
`define SPCG_MAP_VH

// ********************
// Register indices (byte address = index * 4)
// ********************
`define SPCG_IDX_GEN      6'h00
`define SPCG_IDX_ANA_A    6'h01
`define SPCG_IDX_ANA_B    6'h02
`define SPCG_IDX_PORT_C   6'h03
`define SPCG_IDX_PORT_D   6'h04
`define SPCG_IDX_PORT_E   6'h05
`define SPCG_IDX_PORT_F   6'h06
`define SPCG_IDX_SLEEP    6'h08
`define SPCG_IDX_STATUS   6'h09

// ********************
// Writable bit masks and reset values
// ********************
`define SPCG_GEN_MASK     8'h5F
`define SPCG_ANA_MASK     8'h07
`define SPCG_PORT_MASK    8'h7F
`define SPCG_SLEEP_MASK   8'h0F
`define SPCG_RESET_VAL    8'h00

// ********************
// Field positions
// ********************
`define SPCG_SLEEP_ARM_BIT 0
`define SPCG_MODE_LSB     1
`define SPCG_MODE_MSB     3
`define SPCG_GEN_RTC_BIT  2
`define SPCG_GEN_DMA_BIT  0
`define SPCG_ANA_ADC_BIT  1
`define SPCG_ANA_AC_BIT   0

// ********************
// Sleep mode codes
// ********************
`define SPCG_MODE_IDLE      3'h0
`define SPCG_MODE_ALL_OFF   3'h2
`define SPCG_MODE_CNT_KEPT  3'h3
`define SPCG_MODE_SRC_KEPT  3'h6
`define SPCG_MODE_SRC_CNT   3'h7

// ********************
// Timing
// ********************
`define SPCG_WAKE_HALT_CYC  3'h4

// ********************
// Bus responses
// ********************
`define SPCG_RESP_OKAY    2'h0
`define SPCG_RESP_SLVERR  2'h2

`endif

// ---- rtl/spcg_top.v ----
// Operation
// - Gated peripheral clock stops; its state freezes and access is blocked.
// - Clearing a gating bit resumes the clock from the held state.
// - Gating bits of absent peripherals have no effect.
// - Non-idle sleep stops peripheral clocks whatever the gating bits, bar the counter clock in modes 3 and 7.
// - Input buffers are off while sleep stops the peripheral clock.
// - Converter forced off in non-idle sleep.
// - Converter off then on makes the next conversion extended.
// - Comparator off in non-idle sleep; its used reference stays on.
// - Fuse-enabled brownout detector stays on; deep sleep may sample it.
// - Enabled watchdog runs in every sleep mode.
// - Mode field bits 3..1: 0 idle, 2, 3, 6, 7 deeper modes.
// - Sleep instruction enters sleep only with the arm bit set.
// - Reserved bits read zero, are read-only, written as zero.
// - General bits gate USB, AES, external bus, counter, events, DMA.
// - Event routing continues unchanged after ungating.
// - DMA gating bit takes a one only while DMA is off.
// - Analog bits gate DAC, ADC, comparator clocks, not their enables.
// - Port bits gate two-wire, serial 1/0, SPI, hi-res, timers.
// - Ungated timers resume counting from their held state.
// - Core is held four cycles after wake before execution.
// - Each sleep mode stops its set of clocks and sources.
//
// Purpose: Sleep mode control and per-peripheral clock gating.
// Assumes: All inputs come from logic on sys_clk_i.
// Notes:   Gated clock outputs are the only outputs not taken from a flop.
`timescale 1ns/1ps
`include "spcg_map.vh"

module spcg_top
#(
  parameter ADDR_W = 8,
  parameter [41:0] IMPL_MASK = {42{1'b1}}
)
(
  input wire sys_clk_i,
  input wire sys_rst_i,
  // AXI4-Lite slave
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Core and system side
  input wire sleep_instr_i,
  input wire wake_i,
  input wire dma_enabled_i,
  input wire adc_sw_enable_i,
  input wire adc_conv_done_i,
  input wire ac_sw_enable_i,
  input wire ac_uses_vref_i,
  input wire bod_fuse_enable_i,
  input wire bod_sampled_cfg_i,
  input wire wdt_enable_i,
  output wire [41:0] peripheral_clock_o,
  output reg [41:0] periph_access_block_o,
  output reg core_clk_en_o,
  output reg sleeping_o,
  output reg periph_clk_en_o,
  output reg rtc_clk_en_o,
  output reg sys_src_en_o,
  output reg input_buffer_off_o,
  output reg adc_enable_o,
  output reg adc_extended_conv_o,
  output reg ac_enable_o,
  output reg vref_enable_o,
  output reg bod_enable_o,
  output reg bod_sampled_o,
  output reg wdt_run_o
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] ST_ACTIVE = 3'h1;
  localparam [2:0] ST_SLEEP = 3'h2;
  localparam [2:0] ST_WAKE = 3'h4;

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [7:0] general_clock_gating;
  reg [7:0] analog_a_clock_gating;
  reg [7:0] analog_b_clock_gating;
  reg [7:0] port_c_clock_gating;
  reg [7:0] port_d_clock_gating;
  reg [7:0] port_e_clock_gating;
  reg [7:0] port_f_clock_gating;
  reg [7:0] sleep_control;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] active_mode;
  reg [2:0] halt_cnt;
  reg adc_was_off;

  // Bus holding registers
  reg aw_held;
  reg w_held;
  reg [5:0] aw_idx;
  reg [7:0] w_byte;
  reg w_lane0;

  wire [2:0] sleep_mode_select;
  wire sleep_arm_bit;
  wire mode_legal;
  wire deep_sleep;
  wire counter_kept;
  wire sources_kept;
  wire do_write;
  wire [5:0] ar_idx;
  wire [41:0] gate_bits;
  wire [41:0] next_stop;
  wire next_adc_on;

  assign sleep_mode_select =
    sleep_control[`SPCG_MODE_MSB:`SPCG_MODE_LSB];
  assign sleep_arm_bit = sleep_control[`SPCG_SLEEP_ARM_BIT];

  // Reserved codes are not entered: the sleep request is ignored
  assign mode_legal = (sleep_mode_select == `SPCG_MODE_IDLE) ||
                      (sleep_mode_select == `SPCG_MODE_ALL_OFF) ||
                      (sleep_mode_select == `SPCG_MODE_CNT_KEPT) ||
                      (sleep_mode_select == `SPCG_MODE_SRC_KEPT) ||
                      (sleep_mode_select == `SPCG_MODE_SRC_CNT);

  // ****************************************************************
  // Sleep state machine
  // ****************************************************************

  // Sleep entry needs the arm bit; wake holds the core four cycles
  always @*
  begin
    next_state = state;
    case (state)
      ST_ACTIVE:
        if (sleep_instr_i && sleep_arm_bit && mode_legal)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (wake_i)
          next_state = ST_WAKE;
      ST_WAKE:
        if (halt_cnt == `SPCG_WAKE_HALT_CYC - 3'h1)
          next_state = ST_ACTIVE;
      default:
        next_state = ST_ACTIVE;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= ST_ACTIVE;
      active_mode <= `SPCG_MODE_IDLE;
      halt_cnt <= 3'h0;
    end
    else
    begin
      state <= next_state;
      if (state == ST_ACTIVE && next_state == ST_SLEEP)
        active_mode <= sleep_mode_select;
      if (state == ST_WAKE)
        halt_cnt <= halt_cnt + 3'h1;
      else
        halt_cnt <= 3'h0;
    end
  end

  // Mode decode for the state about to be in effect
  wire [2:0] next_mode;
  wire next_asleep;
  assign next_asleep = (next_state == ST_SLEEP);
  assign next_mode = (state == ST_ACTIVE) ? sleep_mode_select : active_mode;
  assign deep_sleep = next_asleep && (next_mode != `SPCG_MODE_IDLE);
  assign counter_kept = (next_mode == `SPCG_MODE_CNT_KEPT) ||
                        (next_mode == `SPCG_MODE_SRC_CNT);
  assign sources_kept = (next_mode == `SPCG_MODE_SRC_KEPT) ||
                        (next_mode == `SPCG_MODE_SRC_CNT);

  // ****************************************************************
  // Clock gating
  // ****************************************************************

  // Bit order: general[7:0], analog A/B [2:0], ports C..F [6:0]
  assign gate_bits = {port_f_clock_gating[6:0], port_e_clock_gating[6:0],
                      port_d_clock_gating[6:0], port_c_clock_gating[6:0],
                      analog_b_clock_gating[2:0], analog_a_clock_gating[2:0],
                      general_clock_gating};

  genvar g;
  generate
    for (g = 0; g < 42; g = g + 1)
    begin : gen_gate
      // Counter clock survives the counter-keeping modes
      if (g == `SPCG_GEN_RTC_BIT)
      begin : gen_rtc
        assign next_stop[g] = IMPL_MASK[g] &
          (gate_bits[g] | (deep_sleep & ~counter_kept));
      end
      else
      begin : gen_plain
        assign next_stop[g] = IMPL_MASK[g] &
          (gate_bits[g] | deep_sleep);
      end

      spcg_clock_gate u_gate
      (
        .clk_i(sys_clk_i),
        .rst_i(sys_rst_i),
        .stop_i(periph_access_block_o[g]),
        .clk_o(peripheral_clock_o[g])
      );
    end
  endgenerate

  // Converter is powered only when software wants it and sleep allows
  assign next_adc_on = adc_sw_enable_i & ~deep_sleep;

  // ****************************************************************
  // Flopped outputs
  // ****************************************************************
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      periph_access_block_o <= {42{1'b0}};
      core_clk_en_o <= 1'b1;
      sleeping_o <= 1'b0;
      periph_clk_en_o <= 1'b1;
      rtc_clk_en_o <= 1'b1;
      sys_src_en_o <= 1'b1;
      input_buffer_off_o <= 1'b0;
      adc_enable_o <= 1'b0;
      adc_was_off <= 1'b0;
      adc_extended_conv_o <= 1'b0;
      ac_enable_o <= 1'b0;
      vref_enable_o <= 1'b0;
      bod_enable_o <= 1'b0;
      bod_sampled_o <= 1'b0;
      wdt_run_o <= 1'b0;
    end
    else
    begin
      periph_access_block_o <= next_stop;
      core_clk_en_o <= (next_state == ST_ACTIVE);
      sleeping_o <= next_asleep;
      periph_clk_en_o <= ~deep_sleep;
      rtc_clk_en_o <= ~deep_sleep | counter_kept;
      sys_src_en_o <= ~deep_sleep | sources_kept;
      input_buffer_off_o <= deep_sleep;
      adc_enable_o <= next_adc_on;
      // Any off period marks the next conversion as extended
      if (!next_adc_on)
        adc_was_off <= 1'b1;
      else if (adc_was_off)
      begin
        adc_was_off <= 1'b0;
        adc_extended_conv_o <= 1'b1;
      end
      else if (adc_conv_done_i)
        adc_extended_conv_o <= 1'b0;
      ac_enable_o <= ac_sw_enable_i & ~deep_sleep;
      // Reference tracks software only; sleep does not drop it
      vref_enable_o <= ac_sw_enable_i & ac_uses_vref_i;
      bod_enable_o <= bod_fuse_enable_i;
      bod_sampled_o <= bod_fuse_enable_i & bod_sampled_cfg_i &
                       deep_sleep;
      wdt_run_o <= wdt_enable_i;
    end
  end

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Address and data are taken in either order, then written together
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 6'h00;
      w_byte <= `SPCG_RESET_VAL;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SPCG_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_idx)
          `SPCG_IDX_GEN, `SPCG_IDX_ANA_A, `SPCG_IDX_ANA_B,
          `SPCG_IDX_PORT_C, `SPCG_IDX_PORT_D, `SPCG_IDX_PORT_E,
          `SPCG_IDX_PORT_F, `SPCG_IDX_SLEEP, `SPCG_IDX_STATUS:
            s_axi_bresp <= `SPCG_RESP_OKAY;
          default:
            s_axi_bresp <= `SPCG_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register stores; reserved bits never leave zero
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      general_clock_gating <= `SPCG_RESET_VAL;
      analog_a_clock_gating <= `SPCG_RESET_VAL;
      analog_b_clock_gating <= `SPCG_RESET_VAL;
      port_c_clock_gating <= `SPCG_RESET_VAL;
      port_d_clock_gating <= `SPCG_RESET_VAL;
      port_e_clock_gating <= `SPCG_RESET_VAL;
      port_f_clock_gating <= `SPCG_RESET_VAL;
      sleep_control <= `SPCG_RESET_VAL;
    end
    else if (do_write && w_lane0)
    begin
      case (aw_idx)
        `SPCG_IDX_GEN:
        begin
          general_clock_gating <= w_byte & `SPCG_GEN_MASK;
          // A one on the DMA bit is refused while DMA runs
          if (dma_enabled_i)
            general_clock_gating[`SPCG_GEN_DMA_BIT] <= 1'b0;
        end
        `SPCG_IDX_ANA_A:
          analog_a_clock_gating <= w_byte & `SPCG_ANA_MASK;
        `SPCG_IDX_ANA_B:
          analog_b_clock_gating <= w_byte & `SPCG_ANA_MASK;
        `SPCG_IDX_PORT_C:
          port_c_clock_gating <= w_byte & `SPCG_PORT_MASK;
        `SPCG_IDX_PORT_D:
          port_d_clock_gating <= w_byte & `SPCG_PORT_MASK;
        `SPCG_IDX_PORT_E:
          port_e_clock_gating <= w_byte & `SPCG_PORT_MASK;
        `SPCG_IDX_PORT_F:
          port_f_clock_gating <= w_byte & `SPCG_PORT_MASK;
        `SPCG_IDX_SLEEP:
          sleep_control <= w_byte & `SPCG_SLEEP_MASK;
        default:
          sleep_control <= sleep_control;
      endcase
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  assign ar_idx = s_axi_araddr[7:2];

  // One read at a time; answer one cycle after the address is taken
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SPCG_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SPCG_RESP_OKAY;
        case (ar_idx)
          `SPCG_IDX_GEN:
            s_axi_rdata <= {24'h000000, general_clock_gating};
          `SPCG_IDX_ANA_A:
            s_axi_rdata <= {24'h000000, analog_a_clock_gating};
          `SPCG_IDX_ANA_B:
            s_axi_rdata <= {24'h000000, analog_b_clock_gating};
          `SPCG_IDX_PORT_C:
            s_axi_rdata <= {24'h000000, port_c_clock_gating};
          `SPCG_IDX_PORT_D:
            s_axi_rdata <= {24'h000000, port_d_clock_gating};
          `SPCG_IDX_PORT_E:
            s_axi_rdata <= {24'h000000, port_e_clock_gating};
          `SPCG_IDX_PORT_F:
            s_axi_rdata <= {24'h000000, port_f_clock_gating};
          `SPCG_IDX_SLEEP:
            s_axi_rdata <= {24'h000000, sleep_control};
          `SPCG_IDX_STATUS:
            s_axi_rdata <= {24'h000000, adc_extended_conv_o,
                            input_buffer_off_o, active_mode, state};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SPCG_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // spcg_top
